/* File: dv/array_model.sv */
/*
  Array timing model: finishes an operation DLY running cycles after start.
  Assumes paused is high while the machine is suspended.
*/
module array_model
#(
  parameter int DLY = 20
)
(
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic start_op,
  input  wire logic busy,
  input  wire logic paused,
  input  wire logic fail_mode,
  output logic      op_done,
  output logic      op_fail
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt; // Running cycles of the operation

  // Counter stops while suspended
  always_ff @(posedge ref_clk)
    if (!rst_b || start_op)
      cnt <= 0;
    else if (busy && !paused)
      cnt <= cnt + 1;

  assign op_done = busy && !paused && cnt == DLY;
  assign op_fail = op_done && fail_mode;
endmodule : array_model

/* File: dv/tb.sv */
/*
  Testbench for the command state machine.
  Assumes the array model drives op_done and op_fail.
*/
module tb
  import flash_cmd_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Stimulus and checks
  // ****************
  logic       ref_clk, rst_b, cmd_we, buf_last, vpp_low, block_locked;
  logic       op_done, op_fail, busy, start_op, fail_mode;
  logic [7:0] cmd_data, status_word;
  logic [2:0] cmd_part, rd_part, busy_part;
  read_mode_t rd_mode;
  int         num_errors, checks;

  always #12.5 ref_clk = ~ref_clk;

  write_state_machine dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .cmd_we(cmd_we),
    .cmd_data(cmd_data), .cmd_part(cmd_part), .buf_last(buf_last), .op_done(op_done),
    .op_fail(op_fail), .vpp_low(vpp_low), .block_locked(block_locked), .rd_part(rd_part),
    .rd_mode(rd_mode), .status_word(status_word), .busy(busy), .busy_part(busy_part),
    .start_op(start_op));
  array_model arr_u (.ref_clk(ref_clk), .rst_b(rst_b), .start_op(start_op), .busy(busy),
    .paused(status_word[2] | status_word[6]), .fail_mode(fail_mode), .op_done(op_done),
    .op_fail(op_fail));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One host write, then an idle cycle
  task automatic wr(input logic [7:0] d, input logic [2:0] p, input logic l);
    @(posedge ref_clk);
    #2;
    cmd_we = 1'b1;
    cmd_data = d;
    cmd_part = p;
    buf_last = l;
    @(posedge ref_clk);
    #2;
    cmd_we = 1'b0;
    buf_last = 1'b0;
  endtask : wr

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 500)
    begin
      @(posedge ref_clk);
      #2;
      n++;
    end
    if (n == 500)
    begin
      num_errors++;
      $display("[ERR] busy expected 0 seen 1");
      finish_test();
    end
  endtask : wait_idle

  task automatic look(input logic [2:0] p, input read_mode_t m);
    rd_part = p;
    repeat (2) @(posedge ref_clk);
    #2;
    chk({6'h00, rd_mode}, {6'h00, m}, "rd_mode");
  endtask : look

  task automatic t_program();
    wr(8'h40, 3'h1, 1'b0);
    wr(8'h5a, 3'h1, 1'b0);
    chk({7'h00, start_op}, 8'h01, "start_op");
    chk(status_word, 8'h00, "status_word");
    wr(8'h20, 3'h2, 1'b0);
    chk({7'h00, busy}, 8'h01, "busy");
    chk({5'h00, busy_part}, 8'h01, "busy_part");
    wr(8'hb0, 3'h1, 1'b0);
    chk({7'h00, status_word[2]}, 8'h01, "suspend bit");
    wr(8'hd0, 3'h1, 1'b0);
    chk({7'h00, status_word[2]}, 8'h00, "suspend bit");
    wait_idle();
    chk(status_word, 8'h80, "status_word");
    $display("test program done");
  endtask : t_program

  task automatic t_errors();
    fail_mode = 1'b1;
    wr(8'h20, 3'h4, 1'b0);
    wr(8'hd0, 3'h4, 1'b0);
    wait_idle();
    fail_mode = 1'b0;
    wr(8'hff, 3'h4, 1'b0);
    chk(status_word, 8'ha0, "status_word");
    wr(8'h50, 3'h4, 1'b0);
    chk(status_word, 8'h80, "status_word");
    wr(8'h20, 3'h0, 1'b0);
    wr(8'hff, 3'h0, 1'b0);
    chk(status_word, 8'hb0, "status_word");
    wr(8'h50, 3'h0, 1'b0);
    wr(8'h60, 3'h0, 1'b0);
    wr(8'hff, 3'h0, 1'b0);
    chk(status_word, 8'h90, "status_word");
    wr(8'h50, 3'h0, 1'b0);
    $display("test errors done");
  endtask : t_errors

  task automatic t_ready_codes();
    logic [7:0] codes [7] = '{8'hff, 8'hd0, 8'hb0, 8'h70, 8'h50, 8'h90, 8'h98};
    foreach (codes[i])
    begin
      wr(codes[i], 3'h0, 1'b0);
      wr(8'hd0, 3'h0, 1'b0);
      chk({busy, status_word[6:0]}, 8'h00, "busy");
    end
    wr(8'h10, 3'h0, 1'b0);
    wr(8'h00, 3'h0, 1'b0);
    chk({7'h00, start_op}, 8'h01, "start_op");
    wait_idle();
    $display("test ready codes done");
  endtask : t_ready_codes

  task automatic t_buffer();
    wr(8'he8, 3'h6, 1'b0);
    wr(8'h02, 3'h6, 1'b0);
    wr(8'h11, 3'h6, 1'b0);
    wr(8'hd0, 3'h6, 1'b0);
    chk({7'h00, busy}, 8'h00, "busy");
    wr(8'h33, 3'h6, 1'b1);
    wr(8'hd0, 3'h6, 1'b0);
    chk({7'h00, start_op}, 8'h01, "start_op");
    wait_idle();
    chk(status_word, 8'h80, "status_word");
    $display("test buffer done");
  endtask : t_buffer

  task automatic t_modes();
    wr(8'h98, 3'h3, 1'b0);
    wr(8'h90, 3'h2, 1'b0);
    wr(8'h70, 3'h1, 1'b0);
    wr(8'hff, 3'h0, 1'b0);
    look(3'h3, 2'h2);
    look(3'h2, 2'h1);
    look(3'h1, 2'h3);
    look(3'h0, 2'h0);
    wr(8'h40, 3'h5, 1'b0);
    wr(8'h00, 3'h5, 1'b0);
    chk({7'h00, start_op}, 8'h01, "start_op");
    wait_idle();
    look(3'h3, 2'h2);
    $display("test modes done");
  endtask : t_modes

  // Start-time error flags, factory and one-time ops, then a reset in mid-run
  task automatic t_flags();
    vpp_low = 1'b1;
    block_locked = 1'b1;
    fail_mode = 1'b1;
    wr(8'h40, 3'h2, 1'b0);
    wr(8'h00, 3'h2, 1'b0);
    vpp_low = 1'b0;
    block_locked = 1'b0;
    chk(status_word, 8'h0a, "status_word");
    wait_idle();
    fail_mode = 1'b0;
    chk(status_word, 8'h9a, "status_word");
    wr(8'h50, 3'h2, 1'b0);
    wr(8'h80, 3'h2, 1'b0);
    wr(8'hd0, 3'h2, 1'b0);
    chk(status_word, 8'h01, "status_word");
    wait_idle();
    chk(status_word, 8'h80, "status_word");
    wr(8'h70, 3'h2, 1'b0);
    wr(8'hc0, 3'h2, 1'b0);
    wr(8'h55, 3'h2, 1'b0);
    chk({7'h00, busy}, 8'h01, "busy");
    look(3'h2, 2'h3);
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    chk(status_word, 8'h80, "status_word");
    chk({7'h00, busy}, 8'h00, "busy");
    look(3'h2, 2'h0);
    $display("test flags done");
  endtask : t_flags

  initial
  begin
    {ref_clk, rst_b, cmd_we, buf_last, vpp_low, block_locked, fail_mode} = '0;
    {cmd_data, cmd_part, rd_part} = '0;
    repeat (4) @(posedge ref_clk);
    #2;
    chk(status_word, 8'h80, "status_word");
    rst_b = 1'b1;
    t_program();
    t_errors();
    t_ready_codes();
    t_buffer();
    t_modes();
    t_flags();
    finish_test();
  end
endmodule : tb

/* File: dv/wsm_sva.sv */
/*
  Port checker for the command state machine.
  Assumes one clock and a synchronous active-low reset.
*/
module wsm_sva
  import flash_cmd_pkg::*;
#(
  parameter int PARTS = 8,
  parameter int PW    = 3
)
(
  input wire logic          ref_clk,
  input wire logic          rst_b,
  input wire logic          cmd_we,
  input wire logic [7:0]    cmd_data,
  input wire logic [PW-1:0] cmd_part,
  input wire logic          buf_last,
  input wire logic          op_done,
  input wire logic          op_fail,
  input wire logic          vpp_low,
  input wire logic          block_locked,
  input wire logic [PW-1:0] rd_part,
  input wire read_mode_t    rd_mode,
  input wire logic [7:0]    status_word,
  input wire logic          busy,
  input wire logic [PW-1:0] busy_part,
  input wire logic          start_op
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************
  // Port relations
  // ****************
  default clocking dc @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  a_reset_clear: assert property (
    disable iff (1'b0) !rst_b |=> status_word == 8'h80 && !busy && !start_op && rd_mode == 2'h0)
    else $error("reset left outputs set");
  a_start_busy: assert property (
    start_op |-> busy && !status_word[7] && $past(cmd_we))
    else $error("start without write or busy");
  a_start_pulse: assert property (
    start_op |=> !start_op)
    else $error("start pulse too long");
  a_done_ready: assert property (
    busy && op_done |=> !busy && status_word[7])
    else $error("completion did not free machine");
  a_suspend_sets: assert property (
    busy && cmd_we && cmd_data == 8'hb0 && !op_done && status_word[6:0] == 7'h00
    |=> status_word[2] || status_word[6])
    else $error("suspend not taken");
  a_stay_busy: assert property (
    busy && cmd_we && cmd_data != 8'hb0 && !op_done |=> busy)
    else $error("busy left on other code");
  a_err_sticky: assert property (
    !(cmd_we && cmd_data == 8'h50) |=> ($past(status_word) & ~status_word & 8'h3a) == 8'h00)
    else $error("error bit cleared by itself");
  a_part_hold: assert property (
    busy ##1 (busy && !start_op) |-> $stable(busy_part))
    else $error("owner changed mid operation");
  a_mode_hold: assert property (
    (!cmd_we && !op_done) [*3] ##0 $stable(rd_part) |=> $stable(rd_mode))
    else $error("read mode changed without command");
endmodule : wsm_sva

bind write_state_machine wsm_sva #(.PARTS(PARTS), .PW(PW)) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .cmd_we(cmd_we), .cmd_data(cmd_data),
  .cmd_part(cmd_part), .buf_last(buf_last), .op_done(op_done), .op_fail(op_fail),
  .vpp_low(vpp_low), .block_locked(block_locked), .rd_part(rd_part), .rd_mode(rd_mode),
  .status_word(status_word), .busy(busy), .busy_part(busy_part), .start_op(start_op));

/* File: shared/flash_cmd_defines.svh */
/*
  Command codes, status word bits and read modes for the flash command state machine.
  Assumes inclusion by bare name from the package and design files.
*/
`ifndef FLASH_CMD_DEFINES_SVH
`define FLASH_CMD_DEFINES_SVH

// ****************************************
// Command codes written by the host
// ****************************************
`define CMD_READ_ARRAY    8'hff
`define CMD_PROGRAM_A     8'h10
`define CMD_PROGRAM_B     8'h40
`define CMD_BUF_PROGRAM   8'he8
`define CMD_ERASE_SETUP   8'h20
`define CMD_FACTORY_SETUP 8'h80
`define CMD_CONFIRM       8'hd0
`define CMD_SUSPEND       8'hb0
`define CMD_READ_STATUS   8'h70
`define CMD_CLEAR_STATUS  8'h50
`define CMD_READ_ID       8'h90
`define CMD_READ_QUERY    8'h98
`define CMD_LOCK_SETUP    8'h60
`define CMD_OTP_SETUP     8'hc0

// ****************************************
// Status word bit positions and reset value
// ****************************************
`define SW_READY        7
`define SW_ERASE_SUSP   6
`define SW_ERASE_ERR    5
`define SW_PROG_ERR     4
`define SW_VPP_ERR      3
`define SW_PROG_SUSP    2
`define SW_LOCK_ERR     1
`define SW_FACTORY_BUSY 0
`define SW_RESET        8'h80

// ****************************************
// Read mode encodings
// ****************************************
`define RM_ARRAY  2'h0
`define RM_IDENT  2'h1
`define RM_QUERY  2'h2
`define RM_STATUS 2'h3

`endif

/* File: shared/flash_cmd_pkg.sv */
/*
  Types shared by the command state machine and its read mode table.
  Assumes the defines header is on the include path.
*/
package flash_cmd_pkg;
  `include "flash_cmd_defines.svh"

  // Read mode presented by a partition
  typedef logic [1:0] read_mode_t;

  // One-hot machine states
  typedef enum logic [17:0] {
    ST_READY        = 18'h00001,
    ST_LOCK_SETUP   = 18'h00002,
    ST_OTP_SETUP    = 18'h00004,
    ST_OTP_BUSY     = 18'h00008,
    ST_PROG_SETUP   = 18'h00010,
    ST_PROG_BUSY    = 18'h00020,
    ST_PROG_SUSP    = 18'h00040,
    ST_BUF_SETUP    = 18'h00080,
    ST_BUF_LOAD1    = 18'h00100,
    ST_BUF_LOAD2    = 18'h00200,
    ST_BUF_CONFIRM  = 18'h00400,
    ST_BUF_BUSY     = 18'h00800,
    ST_BUF_SUSP     = 18'h01000,
    ST_ERASE_SETUP  = 18'h02000,
    ST_ERASE_BUSY   = 18'h04000,
    ST_ERASE_SUSP   = 18'h08000,
    ST_FACT_SETUP   = 18'h10000,
    ST_FACT_BUSY    = 18'h20000
  } wsm_state_t;
endpackage : flash_cmd_pkg

/* File: src/read_mode_table.sv */
/*
  Per-partition read mode memory.
  Assumes a one-cycle write strobe with a partition index and a mode.
*/
`include "flash_cmd_defines.svh"
module read_mode_table
  import flash_cmd_pkg::*;
#(
  parameter int PARTS = 8,
  parameter int PW    = 3
)
(
  input  wire logic            ref_clk,
  input  wire logic            rst_b,
  input  wire logic            set_en,
  input  wire logic [PW-1:0]   set_part,
  input  wire read_mode_t      set_mode,
  input  wire logic [PW-1:0]   rd_part,
  output read_mode_t           rd_mode
);

  // ****************************************
  // Mode storage
  // ****************************************
  read_mode_t mode_q [PARTS];   // One mode per partition

  // Each partition keeps its mode until a new command selects one
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < PARTS; i++)
      begin
        mode_q[i] <= `RM_ARRAY;
      end
    end
    else if (set_en)
    begin
      mode_q[set_part] <= set_mode;
    end
  end

  // Registered lookup of the addressed partition
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      rd_mode <= `RM_ARRAY;
    end
    else
    begin
      rd_mode <= mode_q[rd_part];
    end
  end

endmodule : read_mode_table

/* File: src/write_state_machine.sv */
/*
  Command interpreter of a partitioned flash: state machine, status word, read modes.
  Assumes one host write per cycle on cmd_we, with command data and partition.
  The array operation timing comes from outside on op_done, with its error flags.
*/
`include "flash_cmd_defines.svh"
// Functional notes
// - Query command makes reads return query data
// - Next state from current state and command
// - Only one partition programs or erases
// - Partitions keep last read mode until changed
// - Next state ignores partition read mode
// - Program busy: suspend code suspends, others stay
// - Buffer load 2 waits for last word
// - Machine sets/clears ready, suspends; sets errors only
// - Reset clears status like clear command
module write_state_machine
  import flash_cmd_pkg::*;
#(
  parameter int PARTS = 8,
  parameter int PW    = 3
)
(
  input  wire logic          ref_clk,
  input  wire logic          rst_b,
  input  wire logic          cmd_we,
  input  wire logic [7:0]    cmd_data,
  input  wire logic [PW-1:0] cmd_part,
  input  wire logic          buf_last,
  input  wire logic          op_done,
  input  wire logic          op_fail,
  input  wire logic          vpp_low,
  input  wire logic          block_locked,
  input  wire logic [PW-1:0] rd_part,
  output read_mode_t         rd_mode,
  output logic [7:0]         status_word,
  output logic               busy,
  output logic [PW-1:0]      busy_part,
  output logic               start_op
);

  // ****************************************
  // State
  // ****************************************
  wsm_state_t         state_q;       // Current machine state
  wsm_state_t         state_d;       // Next machine state
  logic               err_cmd;       // Sequence error this cycle
  logic               lock_err;      // Lock sequence error this cycle
  logic               go;            // Operation starts this cycle
  logic               mode_en;       // Read mode update strobe
  read_mode_t         mode_val;      // Read mode to store

  // Is the machine running an array operation
  function automatic logic is_busy(input wsm_state_t s);
    is_busy = (s == ST_PROG_BUSY) || (s == ST_BUF_BUSY) || (s == ST_ERASE_BUSY) ||
              (s == ST_FACT_BUSY) || (s == ST_OTP_BUSY);
  endfunction : is_busy

  // Suspend state that pairs with a suspendable busy state
  function automatic wsm_state_t suspend_of(input wsm_state_t s);
    suspend_of = (s == ST_ERASE_BUSY) ? ST_ERASE_SUSP :
                 (s == ST_BUF_BUSY)   ? ST_BUF_SUSP   : ST_PROG_SUSP;
  endfunction : suspend_of
  // Busy state that a suspend state resumes into
  function automatic wsm_state_t resume_of(input wsm_state_t s);
    resume_of = (s == ST_ERASE_SUSP) ? ST_ERASE_BUSY :
                (s == ST_BUF_SUSP)   ? ST_BUF_BUSY   : ST_PROG_BUSY;
  endfunction : resume_of

  // ****************************************
  // Next state, from state, command, buf_last and op_done
  // ****************************************
  always_comb
  begin
    state_d  = state_q;
    err_cmd  = 1'b0;
    lock_err = 1'b0;
    go       = 1'b0;
    unique case (state_q)
      ST_READY:
      begin
        if (cmd_we)
        begin
          unique case (cmd_data)
            `CMD_PROGRAM_A,
            `CMD_PROGRAM_B:     state_d = ST_PROG_SETUP;
            `CMD_BUF_PROGRAM:   state_d = ST_BUF_SETUP;
            `CMD_ERASE_SETUP:   state_d = ST_ERASE_SETUP;
            `CMD_FACTORY_SETUP: state_d = ST_FACT_SETUP;
            `CMD_LOCK_SETUP:    state_d = ST_LOCK_SETUP;
            `CMD_OTP_SETUP:     state_d = ST_OTP_SETUP;
            default:            state_d = ST_READY;
          endcase
        end
      end
      ST_LOCK_SETUP:
      begin
        if (cmd_we)
        begin
          state_d  = ST_READY;
          lock_err = (cmd_data != `CMD_CONFIRM);   // Anything but confirm is a lock error
        end
      end
      ST_OTP_SETUP,
      ST_PROG_SETUP:
      begin
        if (cmd_we)
        begin
          state_d = (state_q == ST_OTP_SETUP) ? ST_OTP_BUSY : ST_PROG_BUSY;   // Data word
          go      = 1'b1;
        end
      end
      ST_PROG_BUSY,
      ST_BUF_BUSY,
      ST_ERASE_BUSY:
      begin
        if (op_done)
        begin
          state_d = ST_READY;
        end
        else if (cmd_we && cmd_data == `CMD_SUSPEND)
        begin
          state_d = suspend_of(state_q);
        end
      end
      ST_PROG_SUSP,
      ST_BUF_SUSP,
      ST_ERASE_SUSP:
      begin
        if (cmd_we && cmd_data == `CMD_CONFIRM)
        begin
          state_d = resume_of(state_q);   // Resume
        end
      end
      ST_BUF_SETUP:
      begin
        if (cmd_we)
        begin
          state_d = ST_BUF_LOAD1;   // Word count write
        end
      end
      ST_BUF_LOAD1,
      ST_BUF_LOAD2:
      begin
        if (cmd_we)
        begin
          state_d = buf_last ? ST_BUF_CONFIRM : ST_BUF_LOAD2;
        end
      end
      ST_BUF_CONFIRM:
      begin
        if (cmd_we)
        begin
          go      = (cmd_data == `CMD_CONFIRM);
          err_cmd = !go;
          state_d = go ? ST_BUF_BUSY : ST_READY;
        end
      end
      ST_ERASE_SETUP,
      ST_FACT_SETUP:
      begin
        if (cmd_we)
        begin
          go      = (cmd_data == `CMD_CONFIRM);
          err_cmd = !go;
          state_d = !go ? ST_READY :
                    (state_q == ST_ERASE_SETUP) ? ST_ERASE_BUSY : ST_FACT_BUSY;
        end
      end
      ST_OTP_BUSY,
      ST_FACT_BUSY:
      begin
        if (op_done)
        begin
          state_d = ST_READY;
        end
      end
      default:
      begin
        state_d = ST_READY;   // Illegal code recovers to ready
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      state_q <= ST_READY;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Busy partition: a single owner at a time
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      busy      <= 1'b0;
      busy_part <= '0;
      start_op  <= 1'b0;
    end
    else
    begin
      busy     <= is_busy(state_d);
      start_op <= go;
      if (go)
      begin
        busy_part <= cmd_part;   // Only set when idle, so one owner
      end
    end
  end

  // ****************************************
  // Status word
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (!rst_b)
    begin
      status_word <= `SW_RESET;
    end
    else
    begin
      status_word[`SW_READY]        <= !is_busy(state_d);
      status_word[`SW_ERASE_SUSP]   <= (state_d == ST_ERASE_SUSP);
      status_word[`SW_PROG_SUSP]    <= (state_d == ST_PROG_SUSP) || (state_d == ST_BUF_SUSP);
      status_word[`SW_FACTORY_BUSY] <= (state_d == ST_FACT_BUSY);
      // Clear comes first so that a set in the same cycle wins
      if (cmd_we && cmd_data == `CMD_CLEAR_STATUS && state_q == ST_READY)
      begin
        status_word[`SW_ERASE_ERR:`SW_VPP_ERR] <= 3'h0;
        status_word[`SW_LOCK_ERR]              <= 1'b0;
      end
      // Error bits only ever set here
      if (err_cmd || (op_done && op_fail && state_q == ST_ERASE_BUSY))
      begin
        status_word[`SW_ERASE_ERR] <= 1'b1;
      end
      if (err_cmd || lock_err || (op_done && op_fail && state_q != ST_ERASE_BUSY))
      begin
        status_word[`SW_PROG_ERR] <= 1'b1;
      end
      if (go && vpp_low)
      begin
        status_word[`SW_VPP_ERR] <= 1'b1;
      end
      if (go && block_locked)
      begin
        status_word[`SW_LOCK_ERR] <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read mode selection per partition
  // ****************************************
  always_comb
  begin
    mode_en  = 1'b0;
    mode_val = `RM_ARRAY;
    if (cmd_we && (state_q == ST_READY || state_q == ST_PROG_SUSP ||
                   state_q == ST_BUF_SUSP || state_q == ST_ERASE_SUSP))
    begin
      mode_en = 1'b1;
      unique case (cmd_data)
        `CMD_READ_ARRAY:  mode_val = `RM_ARRAY;
        `CMD_READ_ID:     mode_val = `RM_IDENT;
        `CMD_READ_QUERY:  mode_val = `RM_QUERY;
        `CMD_READ_STATUS: mode_val = `RM_STATUS;
        default:          mode_en  = 1'b0;
      endcase
    end
  end

  // Mode memory
  read_mode_table #(
    .PARTS (PARTS),
    .PW    (PW)
  ) u_modes (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .set_en   (mode_en),
    .set_part (cmd_part),
    .set_mode (mode_val),
    .rd_part  (rd_part),
    .rd_mode  (rd_mode)
  );

endmodule : write_state_machine
